// >>> spc_pkg.sv
package spc_pkg;

  // Register offsets on the parallel control port.
  localparam logic [7:0] PIN_FUNCTION_CONFIG_ADDR           = 8'h01;
  localparam logic [7:0] CLOCK_POLARITY_PAYLOAD_CONFIG_ADDR = 8'h02;

  // Values after reset, and the value read back from unmapped addresses.
  localparam logic [7:0] PIN_FUNCTION_CONFIG_RESET           = 8'h00;
  localparam logic [7:0] CLOCK_POLARITY_PAYLOAD_CONFIG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE                 = 8'h00;

  // Field positions of the pin function register.
  localparam int LINE_OUTPUT_FORMAT_BIT     = 0;
  localparam int TX_SYNC_DIRECTION_BIT      = 1;
  localparam int TX_SYNC_FRAMING_SELECT_BIT = 2;
  localparam int COMPOSITE_SYNC_SELECT_BIT  = 3;
  localparam int ALARM_PIN_FUNCTION_BIT     = 4;
  localparam int RX_SYNC_SELECT_A_BIT       = 5;
  localparam int RX_SYNC_SELECT_B_BIT       = 6;
  localparam int STANDARD_TIMING_ENABLE_BIT = 7;

  // Field positions of the clock polarity and payload register.
  localparam int RX_GAPPED_CLOCK_ENABLE_BIT = 0;
  localparam int TX_GAPPED_CLOCK_ENABLE_BIT = 1;
  localparam int TX_SYNC_INVERT_BIT         = 4;
  localparam int RX_SYNC_INVERT_BIT         = 5;
  localparam int TX_CLOCK_INVERT_BIT        = 6;
  localparam int RX_CLOCK_INVERT_BIT        = 7;

  // Line mode codes, shared by transmit and receive mode inputs.
  localparam logic [1:0] MODE_T1   = 2'h0;
  localparam logic [1:0] MODE_E1   = 2'h1;
  localparam logic [1:0] MODE_CC64 = 2'h2;
  localparam logic [1:0] MODE_6312 = 2'h3;

  // Width of a widened sync pulse, in clocks.
  localparam int WIDE_PULSE_CYCLES = 2;

endpackage

// >>> spc_pulse_widen.sv
// Stretches a one-clock sync pulse to two clocks when asked to.
module spc_pulse_widen (
  input  wire logic clk,       // System clock.
  input  wire logic arst_n,    // Asynchronous reset, active low.
  input  wire logic clk_en,    // Freezes all state while low.
  input  wire logic pulse_in,  // One-clock sync pulse from the framer.
  input  wire logic widen,     // High to stretch this pulse.
  output logic      pulse_out  // Registered, possibly stretched pulse.
);

  // Whole state of the shaper.
  typedef struct packed {
    logic armed;  // Previous pulse asked to be widened.
    logic out;    // Output flop.
  } spc_widen_state_t;

  spc_widen_state_t s_q;  // Registered state.
  spc_widen_state_t s_d;  // Next state.

  // The second clock of a wide pulse is the cycle after a widened pulse.
  always_comb begin
    s_d       = s_q;
    s_d.armed = pulse_in & widen;
    s_d.out   = pulse_in | s_q.armed;
  end

  // State register, frozen by the clock enable.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign pulse_out = s_q.out;

endmodule

// >>> spc_pin_config.sv
// Pin function, polarity and payload clock configuration for framing pins.
module spc_pin_config (
  input  wire logic       clk,                  // System clock, 200 MHz.
  input  wire logic       arst_n,               // Asynchronous reset, active low.
  input  wire logic       clk_en,               // Freezes all state while low.
  // Parallel control port.
  input  wire logic [7:0] addr,                 // Register address.
  input  wire logic       wr_en,                // Write strobe, one clock.
  input  wire logic       rd_en,                // Read strobe, one clock.
  input  wire logic [7:0] wdata,                // Write data.
  output logic      [7:0] rdata_q,              // Read data, valid after rd_en.
  // Operating modes.
  input  wire logic [1:0] tx_mode,              // Transmit line mode code.
  input  wire logic [1:0] rx_mode,              // Receive line mode code.
  // Transmit line data from the encoder.
  input  wire logic       bipolar_pos,          // Bipolar positive rail.
  input  wire logic       bipolar_neg,          // Bipolar negative rail.
  input  wire logic       nrz_data,             // NRZ data.
  output logic            tx_line_positive_q,   // Positive line data pin.
  output logic            tx_line_negative_q,   // Negative line data pin.
  // Transmit sync sources and the two-way sync pin.
  input  wire logic       tx_frame_pulse,       // Transmit frame sync.
  input  wire logic       tx_mf_pulse,          // Transmit multiframe sync.
  input  wire logic       tx_sig_frame,         // Transmit frame is a signaling frame.
  input  wire logic       ref_8k_legacy,        // 8kHz reference, legacy timing.
  input  wire logic       ref_8k_std,           // 8kHz reference, standard timing.
  input  wire logic       ref_400_legacy,       // 400Hz reference, legacy timing.
  input  wire logic       ref_400_std,          // 400Hz reference, standard timing.
  input  wire logic       tx_sync_pin_i,        // Sync pin level seen from outside.
  output logic            tx_sync_pin_o_q,      // Sync pin drive value.
  output logic            tx_sync_pin_oe_q,     // Sync pin output enable, high drives.
  output logic            tx_sync_in_q,         // Received external sync to framer.
  // Receive sync sources.
  input  wire logic       rx_frame_pulse,       // Receive frame pulse.
  input  wire logic       rx_mf_pulse,          // Receive T1 multiframe pulse.
  input  wire logic       rx_cas_mf_pulse,      // Receive E1 CAS multiframe boundary.
  input  wire logic       rx_crc4_mf_pulse,     // Receive E1 CRC4 multiframe boundary.
  input  wire logic       rx_sig_frame,         // Receive frame is a signaling frame.
  output logic            rx_sync_pin_q,        // Receive sync output pin.
  // Alarm sources.
  input  wire logic       rx_frame_loss,        // Receive loss of frame.
  input  wire logic       tx_clock_loss,        // Loss of transmit clock.
  input  wire logic       cc_error,             // Composite clock error.
  output logic            shared_alarm_pin_q,   // Shared alarm pin.
  // Clocks as sampled levels, with gap markers.
  input  wire logic       tx_clock_input_pin,   // Transmit clock level.
  input  wire logic       tx_gap,               // Transmit overhead bit position.
  input  wire logic       rx_clk_level,         // Recovered receive clock level.
  input  wire logic       rx_gap,               // Receive overhead bit position.
  output logic            tx_clock_output_pin_q,// Transmit clock output pin.
  output logic            rx_clock_out_q        // Receive clock output pin.
);

  // Whole state of the block, apart from the two pulse stretchers.
  typedef struct packed {
    logic [7:0] pin_function_config;           // Pin function register.
    logic [7:0] clock_polarity_payload_config; // Polarity and payload register.
    logic [7:0] rdata;                         // Read data.
    logic       line_pos;                      // Positive line pin.
    logic       line_neg;                      // Negative line pin.
    logic       sync_o;                        // Sync pin drive.
    logic       sync_oe;                       // Sync pin enable.
    logic       sync_in;                       // External sync to framer.
    logic       rx_sync;                       // Receive sync pin.
    logic       alarm;                         // Shared alarm pin.
    logic       tx_clock_input_pin_out;                      // Transmit clock pin.
    logic       rclk_out;                      // Receive clock pin.
  } spc_state_t;

  spc_state_t s_q;  // Registered state.
  spc_state_t s_d;  // Next state.

  logic tx_wide;    // Transmit sync pulse after widening.
  logic rx_wide;    // Receive frame pulse after widening.
  logic tx_widen;   // Stretch request for transmit sync.
  logic rx_widen;   // Stretch request for receive sync.

  // True for the framed modes in which framing options apply.
  function automatic logic is_framed(input logic [1:0] mode);
    is_framed = (mode == spc_pkg::MODE_T1) || (mode == spc_pkg::MODE_E1);
  endfunction

  // Gaps a clock at overhead positions when enabled in a framed mode.
  function automatic logic gapped_clock(input logic clk_lvl, input logic gap,
                                        input logic en, input logic [1:0] mode);
    gapped_clock = clk_lvl & ~(en & is_framed(mode) & gap);
  endfunction

  // Short aliases for configuration fields.
  logic [7:0] f1;   // Pin function register.
  logic [7:0] f2;   // Polarity and payload register.
  assign f1 = s_q.pin_function_config;
  assign f2 = s_q.clock_polarity_payload_config;

  // Double-wide only in T1 mode, during signaling frames; transmit also needs the output direction.
  assign tx_widen = (tx_mode == spc_pkg::MODE_T1) &
                    f1[spc_pkg::COMPOSITE_SYNC_SELECT_BIT] &
                    f1[spc_pkg::TX_SYNC_DIRECTION_BIT] & tx_sig_frame;
  assign rx_widen = (rx_mode == spc_pkg::MODE_T1) &
                    ~f1[spc_pkg::RX_SYNC_SELECT_A_BIT] &
                    f1[spc_pkg::RX_SYNC_SELECT_B_BIT] & rx_sig_frame;

  // Transmit sync stretcher; its source is the frame or multiframe pulse.
  spc_pulse_widen u_tx_widen (
    .clk       (clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .pulse_in  (f1[spc_pkg::TX_SYNC_FRAMING_SELECT_BIT] ? tx_mf_pulse : tx_frame_pulse),
    .widen     (tx_widen),
    .pulse_out (tx_wide)
  );

  // Receive frame pulse stretcher.
  spc_pulse_widen u_rx_widen (
    .clk       (clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .pulse_in  (rx_frame_pulse),
    .widen     (rx_widen),
    .pulse_out (rx_wide)
  );

  // Next-state logic: register port and all pin multiplexing.
  always_comb begin
    logic tx_src;   // Chosen transmit sync source before inversion.
    logic rx_src;   // Chosen receive sync source before inversion.
    tx_src = 1'b0;
    rx_src = 1'b0;
    s_d    = s_q;

    // Writes store the whole byte, unused bits included, so reads echo it.
    if (wr_en) begin
      if (addr == spc_pkg::PIN_FUNCTION_CONFIG_ADDR) begin
        s_d.pin_function_config = wdata;
      end else if (addr == spc_pkg::CLOCK_POLARITY_PAYLOAD_CONFIG_ADDR) begin
        s_d.clock_polarity_payload_config = wdata;
      end
    end

    // Reads answer one clock later; unmapped addresses read as zero.
    if (rd_en) begin
      if (addr == spc_pkg::PIN_FUNCTION_CONFIG_ADDR) begin
        s_d.rdata = s_q.pin_function_config;
      end else if (addr == spc_pkg::CLOCK_POLARITY_PAYLOAD_CONFIG_ADDR) begin
        s_d.rdata = s_q.clock_polarity_payload_config;
      end else begin
        s_d.rdata = spc_pkg::UNMAPPED_READ_VALUE;
      end
    end

    // Line data format.
    if (f1[spc_pkg::LINE_OUTPUT_FORMAT_BIT]) begin
      s_d.line_pos = nrz_data;
      s_d.line_neg = 1'b0;
    end else begin
      s_d.line_pos = bipolar_pos;
      s_d.line_neg = bipolar_neg;
    end

    // Transmit sync source by mode.
    case (tx_mode)
      spc_pkg::MODE_T1, spc_pkg::MODE_E1: begin
        tx_src = tx_wide;
      end
      spc_pkg::MODE_CC64: begin
        // Standard timing only matters in composite modes.
        if (f1[spc_pkg::COMPOSITE_SYNC_SELECT_BIT]) begin
          tx_src = f1[spc_pkg::STANDARD_TIMING_ENABLE_BIT] ? ref_400_std
                                                           : ref_400_legacy;
        end else begin
          tx_src = f1[spc_pkg::STANDARD_TIMING_ENABLE_BIT] ? ref_8k_std
                                                           : ref_8k_legacy;
        end
      end
      default: begin
        tx_src = tx_frame_pulse;
      end
    endcase

    // Sync pin direction and polarity; input direction releases the pin.
    s_d.sync_oe = f1[spc_pkg::TX_SYNC_DIRECTION_BIT];
    s_d.sync_o  = f1[spc_pkg::TX_SYNC_DIRECTION_BIT] &
                  (tx_src ^ f2[spc_pkg::TX_SYNC_INVERT_BIT]);
    s_d.sync_in = ~f1[spc_pkg::TX_SYNC_DIRECTION_BIT] &
                  (tx_sync_pin_i ^ f2[spc_pkg::TX_SYNC_INVERT_BIT]);

    // Receive sync source by mode and the two select bits.
    case (rx_mode)
      spc_pkg::MODE_T1: begin
        rx_src = f1[spc_pkg::RX_SYNC_SELECT_A_BIT] ? rx_mf_pulse : rx_wide;
      end
      spc_pkg::MODE_E1: begin
        if (f1[spc_pkg::RX_SYNC_SELECT_A_BIT]) begin
          rx_src = f1[spc_pkg::RX_SYNC_SELECT_B_BIT] ? rx_crc4_mf_pulse
                                                     : rx_cas_mf_pulse;
        end else begin
          rx_src = rx_wide;
        end
      end
      default: begin
        rx_src = rx_frame_pulse;
      end
    endcase
    s_d.rx_sync = rx_src ^ f2[spc_pkg::RX_SYNC_INVERT_BIT];

    // Shared alarm pin function.
    case (rx_mode)
      spc_pkg::MODE_T1, spc_pkg::MODE_E1: begin
        s_d.alarm = f1[spc_pkg::ALARM_PIN_FUNCTION_BIT] ? tx_clock_loss
                                                        : rx_frame_loss;
      end
      spc_pkg::MODE_CC64: begin
        s_d.alarm = cc_error;
      end
      default: begin
        s_d.alarm = rx_frame_loss;
      end
    endcase

    // Payload clocks, gapped then inverted.
    s_d.tx_clock_input_pin_out = gapped_clock(tx_clock_input_pin, tx_gap,
                                f2[spc_pkg::TX_GAPPED_CLOCK_ENABLE_BIT], tx_mode) ^
                   f2[spc_pkg::TX_CLOCK_INVERT_BIT];
    s_d.rclk_out = gapped_clock(rx_clk_level, rx_gap,
                                f2[spc_pkg::RX_GAPPED_CLOCK_ENABLE_BIT], rx_mode) ^
                   f2[spc_pkg::RX_CLOCK_INVERT_BIT];
  end

  // State register; unused bits two and three are stored as written, and
  // software is expected to keep them zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.pin_function_config           <= spc_pkg::PIN_FUNCTION_CONFIG_RESET;
      s_q.clock_polarity_payload_config <= spc_pkg::CLOCK_POLARITY_PAYLOAD_CONFIG_RESET;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops.
  assign rdata_q               = s_q.rdata;
  assign tx_line_positive_q    = s_q.line_pos;
  assign tx_line_negative_q    = s_q.line_neg;
  assign tx_sync_pin_o_q       = s_q.sync_o;
  assign tx_sync_pin_oe_q      = s_q.sync_oe;
  assign tx_sync_in_q          = s_q.sync_in;
  assign rx_sync_pin_q         = s_q.rx_sync;
  assign shared_alarm_pin_q    = s_q.alarm;
  assign tx_clock_output_pin_q = s_q.tx_clock_input_pin_out;
  assign rx_clock_out_q        = s_q.rclk_out;

  // Checks sampled only while the clock enable lets state move.
  default clocking cb @(posedge clk iff clk_en); endclocking
  default disable iff (!arst_n);

  a_nrz_neg_low: assert property (
    f1[spc_pkg::LINE_OUTPUT_FORMAT_BIT] |=> !tx_line_negative_q)
    else $error("Negative line pin not held low in NRZ format.");
  a_bipolar_pass: assert property (
    !f1[spc_pkg::LINE_OUTPUT_FORMAT_BIT] |=> tx_line_positive_q == $past(bipolar_pos))
    else $error("Bipolar positive data not passed.");
  a_sync_dir: assert property (
    ##1 tx_sync_pin_oe_q == $past(f1[spc_pkg::TX_SYNC_DIRECTION_BIT]))
    else $error("Sync pin enable does not follow direction bit.");
  a_alarm_select: assert property (
    (rx_mode == spc_pkg::MODE_E1 && f1[spc_pkg::ALARM_PIN_FUNCTION_BIT])
      |=> shared_alarm_pin_q == $past(tx_clock_loss))
    else $error("Alarm pin does not show transmit clock loss.");
  a_cc_alarm: assert property (
    rx_mode == spc_pkg::MODE_CC64 |=> shared_alarm_pin_q == $past(cc_error))
    else $error("Alarm pin does not show composite clock error.");
  a_e1_crc4_sync: assert property (
    (rx_mode == spc_pkg::MODE_E1 && f1[spc_pkg::RX_SYNC_SELECT_A_BIT] &&
     f1[spc_pkg::RX_SYNC_SELECT_B_BIT])
      |=> rx_sync_pin_q == ($past(rx_crc4_mf_pulse) ^ $past(f2[spc_pkg::RX_SYNC_INVERT_BIT])))
    else $error("Receive sync does not mark CRC4 boundaries.");
  a_rx_gap_clock: assert property (
    (rx_mode == spc_pkg::MODE_T1 && f2[spc_pkg::RX_GAPPED_CLOCK_ENABLE_BIT] && rx_gap &&
     !f2[spc_pkg::RX_CLOCK_INVERT_BIT]) |=> !rx_clock_out_q)
    else $error("Receive clock not gapped at overhead bit.");
  a_tx_clk_inv: assert property (
    (!f2[spc_pkg::TX_GAPPED_CLOCK_ENABLE_BIT] && f2[spc_pkg::TX_CLOCK_INVERT_BIT])
      |=> tx_clock_output_pin_q == !$past(tx_clock_input_pin))
    else $error("Transmit clock not inverted.");
  a_cfg_readback: assert property (
    (wr_en && addr == spc_pkg::PIN_FUNCTION_CONFIG_ADDR) ##1 !wr_en ##1
    (rd_en && addr == spc_pkg::PIN_FUNCTION_CONFIG_ADDR && !wr_en)
      |=> rdata_q == $past(wdata, 3))
    else $error("Pin function register does not read back.");
  a_tx_wide_pulse: assert property (
    (tx_mode == spc_pkg::MODE_T1 && tx_widen && tx_frame_pulse &&
     !f1[spc_pkg::TX_SYNC_FRAMING_SELECT_BIT])
      ##1 (tx_mode == spc_pkg::MODE_T1 && f1 == $past(f1) && f2 == $past(f2))
      |=> (tx_sync_pin_o_q != $past(f2[spc_pkg::TX_SYNC_INVERT_BIT]))[*2])
    else $error("Transmit sync pulse not two clocks wide.");

  c_nrz_mode:     cover property (f1[spc_pkg::LINE_OUTPUT_FORMAT_BIT] && nrz_data);
  c_sync_output:  cover property (tx_sync_pin_oe_q && tx_sync_pin_o_q);
  c_rx_wide:      cover property (rx_widen && rx_frame_pulse);
  c_cc_400:       cover property (tx_mode == spc_pkg::MODE_CC64 &&
                                  f1[spc_pkg::COMPOSITE_SYNC_SELECT_BIT]);

endmodule

// >>> spc_framer_model.sv
// System-side framing and timing source that feeds the sync pins.
module spc_framer_model (
  input  wire logic clk,              // System clock.
  input  wire logic arst_n,           // Reset, active low.
  input  wire logic tx_sync_pin_oe_q, // Block drives the sync pin.
  output logic      ext_sync,         // Our drive onto the sync pin.
  output logic      tx_frame_pulse,   // Transmit frame sync.
  output logic      tx_mf_pulse,      // Transmit multiframe sync.
  output logic      tx_sig_frame,     // Transmit signaling frame.
  output logic      ref_8k_legacy,    // 8kHz reference, legacy.
  output logic      ref_8k_std,       // 8kHz reference, standard.
  output logic      ref_400_legacy,   // 400Hz reference, legacy.
  output logic      ref_400_std,      // 400Hz reference, standard.
  output logic      rx_frame_pulse,   // Receive frame pulse.
  output logic      rx_mf_pulse,      // Receive multiframe pulse.
  output logic      rx_cas_mf_pulse,  // Receive CAS boundary.
  output logic      rx_crc4_mf_pulse, // Receive CRC4 boundary.
  output logic      rx_sig_frame      // Receive signaling frame.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [6:0] cnt_q; // Frame position; odd offsets keep the pulses apart.

  // The position advances every clock, so every source moves just after an edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  // Pulses are one clock wide and at least eight clocks apart, so widening never merges them.
  assign {tx_frame_pulse, tx_mf_pulse} = {cnt_q[2:0] == 3'h0, cnt_q[4:0] == 5'h03};
  assign {rx_frame_pulse, rx_mf_pulse} = {cnt_q[2:0] == 3'h4, cnt_q[4:0] == 5'h09};
  assign {rx_cas_mf_pulse, rx_crc4_mf_pulse} = {cnt_q[5:0] == 6'h11, cnt_q == 7'h21};
  assign {tx_sig_frame, rx_sig_frame} = {cnt_q[4], cnt_q[5]};
  assign {ref_8k_legacy, ref_8k_std, ref_400_legacy, ref_400_std} =
         {cnt_q[1], cnt_q[2], cnt_q[3], cnt_q[5]};
  // We only drive the pin while the block leaves it as an input.
  assign ext_sync = !tx_sync_pin_oe_q && (cnt_q[2:0] == 3'h5);
endmodule

// >>> sync_pin_io_config_tb.sv
// Register-driven bench that rebuilds every pin from the sampled sources.
module sync_pin_io_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // One snapshot of every source the block samples.
  typedef struct packed {
    logic fp, mf, sig, r8l, r8s, r4l, r4s, pin, rfp, rmf, rcas, rcrc, rsig;
    logic rfl, tcl, cce, tck, tg, rck, rg, bp, bn, nrz;
  } spc_hist_t;

  localparam logic [7:0] PF = spc_pkg::PIN_FUNCTION_CONFIG_ADDR;
  localparam logic [7:0] CP = spc_pkg::CLOCK_POLARITY_PAYLOAD_CONFIG_ADDR;
  // Scenario table: modes and register values; bits 2 and 3 of the second stay zero.
  localparam logic [1:0] TM [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1,
                                     2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
  localparam logic [1:0] RM [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1,
                                     2'h2, 2'h2, 2'h2, 2'h3, 2'h2};
  localparam logic [7:0] C1 [11] = '{8'h00, 8'h5B, 8'h26, 8'h22, 8'h66, 8'h12,
                                     8'h02, 8'h8A, 8'h08, 8'h82, 8'h02};
  localparam logic [7:0] C2 [11] = '{8'h00, 8'hF3, 8'h30, 8'h03, 8'hC0, 8'h00,
                                     8'h10, 8'h03, 8'h10, 8'h01, 8'h20};

  logic       clk, arst_n, clk_en, wr_en, rd_en, chk_on;            // Clock, reset, strobes.
  logic [7:0] addr, wdata, rdata_q, cfg1, cfg2;                     // Port and register shadow.
  logic [1:0] tx_mode, rx_mode;                                     // Line modes.
  logic [6:0] stim_q;                                               // Bench-side source counter.
  logic       bipolar_pos, bipolar_neg, nrz_data, tx_line_positive_q, tx_line_negative_q;
  logic       tx_frame_pulse, tx_mf_pulse, tx_sig_frame, ref_8k_legacy, ref_8k_std;
  logic       ref_400_legacy, ref_400_std, tx_sync_pin_i, tx_sync_pin_o_q, tx_sync_pin_oe_q;
  logic       tx_sync_in_q, ext_sync, rx_frame_pulse, rx_mf_pulse, rx_cas_mf_pulse;
  logic       rx_crc4_mf_pulse, rx_sig_frame, rx_sync_pin_q, rx_frame_loss, tx_clock_loss;
  logic       cc_error, shared_alarm_pin_q, tx_clock_input_pin, tx_gap, rx_clk_level, rx_gap;
  logic       tx_clock_output_pin_q, rx_clock_out_q;
  spc_hist_t  cur, h1, h2, h3;                                      // Sources and their history.
  int         mismatches, compares;                                 // Verdict counters.

  spc_pin_config dut_u (.*);
  spc_framer_model frm_u (.*);

  // The wire level follows whichever side enables its driver.
  assign tx_sync_pin_i = tx_sync_pin_oe_q ? tx_sync_pin_o_q : ext_sync;
  // Line data, alarms and clocks come from our own counter with unrelated periods.
  assign {bipolar_pos, bipolar_neg, nrz_data} = {stim_q[1], stim_q[2], stim_q[0] ^ stim_q[3]};
  assign {rx_frame_loss, tx_clock_loss, cc_error} = {stim_q[3], stim_q[4] ^ stim_q[1], stim_q[6]};
  assign {tx_clock_input_pin, tx_gap} = {stim_q[0], stim_q[3:2] == 2'h0};
  assign {rx_clk_level, rx_gap} = {stim_q[1], stim_q[4:3] == 2'h1};
  assign cur = {tx_frame_pulse, tx_mf_pulse, tx_sig_frame, ref_8k_legacy, ref_8k_std,
                ref_400_legacy, ref_400_std, tx_sync_pin_i, rx_frame_pulse, rx_mf_pulse,
                rx_cas_mf_pulse, rx_crc4_mf_pulse, rx_sig_frame, rx_frame_loss, tx_clock_loss,
                cc_error, tx_clock_input_pin, tx_gap, rx_clk_level, rx_gap, bipolar_pos,
                bipolar_neg, nrz_data};

  always #2.5 clk = ~clk;

  // History is taken with the same edge the block samples on, so no race.
  always @(posedge clk) begin
    stim_q <= stim_q + 7'h01;
    h1 <= cur;
    h2 <= h1;
    h3 <= h2;
  end

  task automatic print_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk1(input logic exp, input logic got);
    check({7'h00, exp}, {7'h00, got});
  endtask

  // A write is a one-clock strobe; the shadow follows only when the block is enabled.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    if (clk_en && a == PF) cfg1 = d;
    if (clk_en && a == CP) cfg2 = d;
  endtask

  // Read data is registered, so it is looked at one edge after the strobe.
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check(exp, rdata_q);
  endtask

  // Checking pauses while modes and registers change, then runs a full counter period.
  task automatic run(input int i);
    chk_on = 1'b0;
    @(posedge clk);
    tx_mode <= TM[i];
    rx_mode <= RM[i];
    reg_wr(PF, C1[i]);
    reg_rd(PF, C1[i]);
    reg_wr(CP, C2[i]);
    reg_rd(CP, C2[i]);
    repeat (4) @(posedge clk);
    chk_on = 1'b1;
    repeat (140) @(posedge clk);
  endtask

  // Each settled cycle every pin is rebuilt from history and the shadow registers.
  always @(negedge clk) begin
    logic tfr, rfr, t2, t3, w3, v;
    if (chk_on) begin
      tfr = tx_mode inside {spc_pkg::MODE_T1, spc_pkg::MODE_E1};
      rfr = rx_mode inside {spc_pkg::MODE_T1, spc_pkg::MODE_E1};
      t2 = cfg1[2] ? h2.mf : h2.fp;
      t3 = cfg1[2] ? h3.mf : h3.fp;
      w3 = cfg1[3] && cfg1[1] && (tx_mode == spc_pkg::MODE_T1) && h3.sig;
      v = cfg1[7] ? (cfg1[3] ? h1.r4s : h1.r8s) : (cfg1[3] ? h1.r4l : h1.r8l);
      // The 6312kHz mode passes the frame sync straight through.
      if (tx_mode == spc_pkg::MODE_6312) v = h1.fp;
      v = tfr ? (t2 || (t3 && w3)) : v;
      chk1(cfg1[0] ? h1.nrz : h1.bp, tx_line_positive_q);
      chk1(cfg1[0] ? 1'b0 : h1.bn, tx_line_negative_q);
      chk1(cfg1[1], tx_sync_pin_oe_q);
      chk1(cfg1[1] && (v ^ cfg2[4]), tx_sync_pin_o_q);
      chk1(!cfg1[1] && (h1.pin ^ cfg2[4]), tx_sync_in_q);
      v = (rx_mode == spc_pkg::MODE_CC64) ? h1.cce : h1.rfl;
      chk1(rfr ? (cfg1[4] ? h1.tcl : h1.rfl) : v, shared_alarm_pin_q);
      chk1(((cfg2[1] && tfr && h1.tg) ? 1'b0 : h1.tck) ^ cfg2[6],
           tx_clock_output_pin_q);
      chk1(((cfg2[0] && rfr && h1.rg) ? 1'b0 : h1.rck) ^ cfg2[7], rx_clock_out_q);
      if (rfr) begin
        v = (rx_mode == spc_pkg::MODE_T1) ? h1.rmf : (cfg1[6] ? h1.rcrc : h1.rcas);
        t2 = h2.rfp || (h3.rfp && cfg1[6] && (rx_mode == spc_pkg::MODE_T1) && h3.rsig);
        chk1((cfg1[5] ? v : t2) ^ cfg2[5], rx_sync_pin_q);
      end else begin
        // Unframed receive modes carry the plain frame pulse.
        chk1(h1.rfp ^ cfg2[5], rx_sync_pin_q);
      end
    end
  end

  // Main sequence: reset values, refused accesses, a frozen write, then the table.
  initial begin
    {clk, arst_n, clk_en, wr_en, rd_en, chk_on} = 6'b001000;
    {addr, wdata, cfg1, cfg2, stim_q} = 39'h0;
    tx_mode = spc_pkg::MODE_T1;
    rx_mode = spc_pkg::MODE_T1;
    mismatches = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    reg_rd(PF, spc_pkg::PIN_FUNCTION_CONFIG_RESET);
    reg_rd(CP, spc_pkg::CLOCK_POLARITY_PAYLOAD_CONFIG_RESET);
    reg_wr(8'h03, 8'hFF);
    reg_rd(8'h03, spc_pkg::UNMAPPED_READ_VALUE);
    reg_rd(8'h00, spc_pkg::UNMAPPED_READ_VALUE);
    reg_rd(CP, 8'h00);
    @(posedge clk);
    clk_en <= 1'b0;
    reg_wr(PF, 8'hFF);
    @(posedge clk);
    clk_en <= 1'b1;
    reg_rd(PF, 8'h00);
    for (int i = 0; i < 11; i++) run(i);
    print_verdict();
  end

  // The table needs about 1700 clocks; a hang is cut off well beyond that.
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
